// File: core/app_sel_params.sv
`timescale 1ns/100ps
`include "app_sel_defines.svh"
module app_sel_params
   import app_sel_pkg::*;
#(
   parameter int POS_W = 32
) (
   input  wire logic             mclk,
   input  wire logic             sys_rst,
   input  wire logic [3:0]       reg_addr,
   input  wire logic [15:0]      reg_wdata,
   input  wire logic             reg_wr,
   input  wire logic             reg_rd,
   output logic      [15:0]      reg_rdata_q,
   input  wire logic             forward_travel_limit_input,
   input  wire logic             reverse_travel_limit_input,
   input  wire logic [POS_W-1:0] position,
   output logic                  motorless_test_en_q,
   output enc_res_t              enc_res_q,
   output enc_type_t             enc_type_q,
   output logic                  ot_warning_en_q,
   output logic                  maint_warning_en_q,
   output logic                  fwd_ot_q,
   output logic                  rev_ot_q,
   output logic                  write_reject_q
);
   // pending copies, software visible
   logic [15:0] pend_test_q, pend_test_d;
   logic [15:0] pend_otw_q, pend_otw_d;
   logic [15:0] pend_mnt_q, pend_mnt_d;
   logic [15:0] pend_rel_q, pend_rel_d;
   // active copies, steering the outputs
   logic [15:0] act_test_q, act_test_d;
   logic [15:0] act_otw_q, act_otw_d;
   logic [15:0] act_mnt_q, act_mnt_d;
   logic [15:0] act_rel_q, act_rel_d;
   logic [15:0] reg_rdata_d;
   logic        motorless_test_en_d;
   enc_res_t    enc_res_d;
   enc_type_t   enc_type_d;
   logic        ot_warning_en_d;
   logic        maint_warning_en_d;
   logic        write_reject_d;
   logic        restart;
   ot_release_t release_mode;

   // each digit must not exceed the digit of the range maximum
   function automatic logic in_range(input logic [15:0] v, input logic [15:0] max);
      in_range = (v[3:0] <= max[3:0]) && (v[7:4] <= max[7:4])
                 && (v[11:8] <= max[11:8]) && (v[15:12] <= max[15:12]);
   endfunction : in_range

   function automatic logic [3:0] digit(input logic [15:0] v, input int lsb);
      digit = v[lsb +: 4];
   endfunction : digit

   // restart strobe: write of 1 to bit 0 of the restart register
   assign restart = reg_wr && (reg_addr == `OFS_RESTART) && reg_wdata[0];

   always_comb begin
      pend_test_d    = pend_test_q;
      pend_otw_d     = pend_otw_q;
      pend_mnt_d     = pend_mnt_q;
      pend_rel_d     = pend_rel_q;
      write_reject_d = write_reject_q;
      if (reg_wr) begin
         unique case (reg_addr)
            `OFS_MOTORLESS_TEST: begin
               if (in_range(reg_wdata, `MAX_MOTORLESS_TEST)) pend_test_d = reg_wdata;
               else write_reject_d = 1'b1;
            end
            `OFS_OT_WARNING: begin
               if (in_range(reg_wdata, `MAX_OT_WARNING)) pend_otw_d = reg_wdata;
               else write_reject_d = 1'b1;
            end
            `OFS_MAINT_WARNING: begin
               if (in_range(reg_wdata, `MAX_MAINT_WARNING)) pend_mnt_d = reg_wdata;
               else write_reject_d = 1'b1;
            end
            `OFS_OT_RELEASE: begin
               if (in_range(reg_wdata, `MAX_OT_RELEASE)) pend_rel_d = reg_wdata;
               else write_reject_d = 1'b1;
            end
            // reserved word is fixed at zero; writers must leave it alone
            // a zero write must not clear the sticky flag, only a write to the restart register does
            `OFS_RESERVED_WORD: begin
               if (reg_wdata != `RESET_VALUE) write_reject_d = 1'b1;
            end
            `OFS_RESTART: write_reject_d = 1'b0;
            default: ;
         endcase
      end
   end

   always_comb begin
      act_test_d = restart ? pend_test_q : act_test_q;
      act_otw_d  = restart ? pend_otw_q  : act_otw_q;
      act_mnt_d  = restart ? pend_mnt_q  : act_mnt_q;
      act_rel_d  = restart ? pend_rel_q  : act_rel_q;
   end

   always_comb begin
      motorless_test_en_d = digit(act_test_q, `DIGIT0_LSB) == 4'h1;
      enc_res_d           = enc_res_t'(act_test_q[`DIGIT1_LSB +: 2]);
      enc_type_d          = enc_type_t'(act_test_q[`DIGIT2_LSB]);
      ot_warning_en_d     = digit(act_otw_q, `DIGIT3_LSB) == 4'h1;
      maint_warning_en_d  = digit(act_mnt_q, `DIGIT0_LSB) == 4'h1;
   end
   assign release_mode = ot_release_t'(act_rel_q[`DIGIT0_LSB]);

   always_comb begin
      reg_rdata_d = 16'h0000;
      if (reg_rd) begin
         unique case (reg_addr)
            `OFS_MOTORLESS_TEST: reg_rdata_d = pend_test_q;
            `OFS_OT_WARNING:     reg_rdata_d = pend_otw_q;
            `OFS_MAINT_WARNING:  reg_rdata_d = pend_mnt_q;
            `OFS_OT_RELEASE:     reg_rdata_d = pend_rel_q;
            `OFS_ACTIVE_STATUS:  reg_rdata_d = {8'h00, 1'b0, maint_warning_en_q,
                                                ot_warning_en_q, enc_type_q,
                                                enc_res_q, motorless_test_en_q,
                                                release_mode};
            `OFS_OT_STATUS:      reg_rdata_d = {13'h0000, write_reject_q, rev_ot_q, fwd_ot_q};
            default:             reg_rdata_d = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         pend_test_q         <= `RESET_VALUE;
         pend_otw_q          <= `RESET_VALUE;
         pend_mnt_q          <= `RESET_VALUE;
         pend_rel_q          <= `RESET_VALUE;
         act_test_q          <= `RESET_VALUE;
         act_otw_q           <= `RESET_VALUE;
         act_mnt_q           <= `RESET_VALUE;
         act_rel_q           <= `RESET_VALUE;
         reg_rdata_q         <= 16'h0000;
         motorless_test_en_q <= 1'b0;
         enc_res_q           <= ENC_RES_13;
         enc_type_q          <= ENC_INCREMENTAL;
         ot_warning_en_q     <= 1'b0;
         maint_warning_en_q  <= 1'b0;
         write_reject_q      <= 1'b0;
      end else begin
         pend_test_q         <= pend_test_d;
         pend_otw_q          <= pend_otw_d;
         pend_mnt_q          <= pend_mnt_d;
         pend_rel_q          <= pend_rel_d;
         act_test_q          <= act_test_d;
         act_otw_q           <= act_otw_d;
         act_mnt_q           <= act_mnt_d;
         act_rel_q           <= act_rel_d;
         reg_rdata_q         <= reg_rdata_d;
         motorless_test_en_q <= motorless_test_en_d;
         enc_res_q           <= enc_res_d;
         enc_type_q          <= enc_type_d;
         ot_warning_en_q     <= ot_warning_en_d;
         maint_warning_en_q  <= maint_warning_en_d;
         write_reject_q      <= write_reject_d;
      end
   end

   ot_release_tracker #(.POS_W(POS_W)) u_tracker (
      .mclk         (mclk),
      .sys_rst      (sys_rst),
      .release_mode (release_mode),
      .fwd_limit    (forward_travel_limit_input),
      .rev_limit    (reverse_travel_limit_input),
      .position     (position),
      .fwd_ot_q     (fwd_ot_q),
      .rev_ot_q     (rev_ot_q)
   );

   a_test_enable : assert property (@(posedge mclk) disable iff (sys_rst)
      ##1 (motorless_test_en_q == ($past(act_test_q[3:0]) == 4'h1)))
      else $error("motorless test enable not from active digit 0");
   a_enc_res_map : assert property (@(posedge mclk) disable iff (sys_rst)
      ##1 (enc_res_q == enc_res_t'($past(act_test_q[5:4]))))
      else $error("encoder resolution mismatch");
   a_enc_type_map : assert property (@(posedge mclk) disable iff (sys_rst)
      ##1 (enc_type_q == enc_type_t'($past(act_test_q[8]))))
      else $error("encoder type mismatch");
   a_otw_enable : assert property (@(posedge mclk) disable iff (sys_rst)
      ##1 (ot_warning_en_q == ($past(act_otw_q[15:12]) == 4'h1)))
      else $error("overtravel warning enable mismatch");
   a_maint_enable : assert property (@(posedge mclk) disable iff (sys_rst)
      ##1 (maint_warning_en_q == ($past(act_mnt_q[3:0]) == 4'h1)))
      else $error("maintenance warning enable mismatch");
   a_no_early_apply : assert property (@(posedge mclk) disable iff (sys_rst)
      !restart |=> $stable(act_test_q) && $stable(act_otw_q)
                   && $stable(act_mnt_q) && $stable(act_rel_q))
      else $error("active copy changed without restart");
   a_restart_apply : assert property (@(posedge mclk) disable iff (sys_rst)
      restart |=> (act_test_q == $past(pend_test_q)) && (act_rel_q == $past(pend_rel_q)))
      else $error("restart did not apply pending copy");
   a_reject_clear : assert property (@(posedge mclk) disable iff (sys_rst)
      restart |=> !write_reject_q)
      else $error("reject flag not cleared by restart");
   a_reject_test : assert property (@(posedge mclk) disable iff (sys_rst)
      (reg_wr && reg_addr == `OFS_MOTORLESS_TEST && !in_range(reg_wdata, `MAX_MOTORLESS_TEST))
      |=> $stable(pend_test_q) && write_reject_q)
      else $error("out of range test setting altered stored value");
   a_reserved_flag : assert property (@(posedge mclk) disable iff (sys_rst)
      (reg_wr && reg_addr == `OFS_RESERVED_WORD && reg_wdata != `RESET_VALUE) |=> write_reject_q)
      else $error("nonzero reserved write not flagged");
   a_reject_keeps : assert property (@(posedge mclk) disable iff (sys_rst)
      (reg_wr && reg_addr == `OFS_OT_RELEASE && !in_range(reg_wdata, `MAX_OT_RELEASE))
      |=> $stable(pend_rel_q) && write_reject_q)
      else $error("out of range write altered stored value");
   a_reserved_zero : assert property (@(posedge mclk) disable iff (sys_rst)
      (reg_rd && reg_addr == `OFS_RESERVED_WORD) |=> (reg_rdata_q == 16'h0000))
      else $error("reserved word not read as zero");
endmodule : app_sel_params

// File: core/app_sel_defines.svh
`ifndef APP_SEL_DEFINES_SVH
`define APP_SEL_DEFINES_SVH
// register offsets on the plain port
`define OFS_MOTORLESS_TEST   4'h0
`define OFS_OT_WARNING       4'h1
`define OFS_MAINT_WARNING    4'h2
`define OFS_RESERVED_WORD    4'h3
`define OFS_OT_RELEASE       4'h4
`define OFS_ACTIVE_STATUS    4'h5
`define OFS_RESTART          4'h6
`define OFS_OT_STATUS        4'h7
// permitted setting ranges (upper bound per digit)
`define MAX_MOTORLESS_TEST   16'h0131
`define MAX_OT_WARNING       16'h1001
`define MAX_MAINT_WARNING    16'h2011
`define MAX_OT_RELEASE       16'h0011
`define RESET_VALUE          16'h0000
// digit field positions
`define DIGIT0_LSB           0
`define DIGIT1_LSB           4
`define DIGIT2_LSB           8
`define DIGIT3_LSB           12
`endif

// File: core/app_sel_pkg.sv
package app_sel_pkg;
   typedef enum logic [1:0] {
      ENC_RES_13,
      ENC_RES_20,
      ENC_RES_22,
      ENC_RES_24
   } enc_res_t;
   typedef enum logic {
      ENC_INCREMENTAL,
      ENC_ABSOLUTE
   } enc_type_t;
   typedef enum logic {
      REL_WHILE_INPUT,
      REL_BY_POSITION
   } ot_release_t;
endpackage : app_sel_pkg

// File: core/ot_release_tracker.sv
`timescale 1ns/100ps
`include "app_sel_defines.svh"
// latches the position where a limit input first asserts and decides overtravel
module ot_release_tracker
   import app_sel_pkg::*;
#(
   parameter int POS_W = 32
) (
   input  wire logic             mclk,
   input  wire logic             sys_rst,
   input  wire ot_release_t      release_mode,
   input  wire logic             fwd_limit,
   input  wire logic             rev_limit,
   input  wire logic [POS_W-1:0] position,
   output logic                  fwd_ot_q,
   output logic                  rev_ot_q
);
   logic [POS_W-1:0] fwd_pos_q;
   logic [POS_W-1:0] fwd_pos_d;
   logic [POS_W-1:0] rev_pos_q;
   logic [POS_W-1:0] rev_pos_d;
   logic             fwd_seen_q;
   logic             fwd_seen_d;
   logic             rev_seen_q;
   logic             rev_seen_d;
   logic             fwd_ot_d;
   logic             rev_ot_d;

   always_comb begin
      fwd_seen_d = fwd_limit;
      rev_seen_d = rev_limit;
      fwd_pos_d  = (fwd_limit && !fwd_seen_q) ? position : fwd_pos_q;
      rev_pos_d  = (rev_limit && !rev_seen_q) ? position : rev_pos_q;
      if (release_mode == REL_WHILE_INPUT) begin
         fwd_ot_d = fwd_limit;
         rev_ot_d = rev_limit;
      end else begin
         // signed compare: forward beyond means larger, reverse smaller
         fwd_ot_d = fwd_limit && fwd_seen_q
                    && ($signed(position) > $signed(fwd_pos_q));
         rev_ot_d = rev_limit && rev_seen_q
                    && ($signed(position) < $signed(rev_pos_q));
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         fwd_pos_q  <= '0;
         rev_pos_q  <= '0;
         fwd_seen_q <= 1'b0;
         rev_seen_q <= 1'b0;
         fwd_ot_q   <= 1'b0;
         rev_ot_q   <= 1'b0;
      end else begin
         fwd_pos_q  <= fwd_pos_d;
         rev_pos_q  <= rev_pos_d;
         fwd_seen_q <= fwd_seen_d;
         rev_seen_q <= rev_seen_d;
         fwd_ot_q   <= fwd_ot_d;
         rev_ot_q   <= rev_ot_d;
      end
   end

   a_mode0_follow : assert property (@(posedge mclk) disable iff (sys_rst)
      (release_mode == REL_WHILE_INPUT) |=> (fwd_ot_q == $past(fwd_limit)))
      else $error("forward overtravel does not follow limit input");
   a_mode1_needs_limit : assert property (@(posedge mclk) disable iff (sys_rst)
      (release_mode == REL_BY_POSITION && !fwd_limit && !rev_limit)
      |=> (!fwd_ot_q && !rev_ot_q))
      else $error("overtravel without a limit input in position mode");
endmodule : ot_release_tracker

// File: testbench/drive_application_selection_params_tb_top.sv
`timescale 1ns/100ps
`include "app_sel_defines.svh"
module drive_application_selection_params_tb_top;
   import app_sel_pkg::*;
   logic        mclk        = 1'b0;
   logic        sys_rst     = 1'b1;
   logic [3:0]  reg_addr    = 4'h0;
   logic [15:0] reg_wdata   = 16'h0000;
   logic        reg_wr      = 1'b0;
   logic        reg_rd      = 1'b0;
   logic [15:0] reg_rdata_q;
   logic        fwd_lim     = 1'b0;
   logic        rev_lim     = 1'b0;
   logic [31:0] position    = 32'h0000_0000;
   logic        motorless_test_en_q;
   enc_res_t    enc_res_q;
   enc_type_t   enc_type_q;
   logic        ot_warning_en_q;
   logic        maint_warning_en_q;
   logic        fwd_ot_q;
   logic        rev_ot_q;
   logic        write_reject_q;
   int          errors      = 0;
   int          check_count = 0;

   app_sel_params app_sel_params_i (
      .mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
      .forward_travel_limit_input(fwd_lim), .reverse_travel_limit_input(rev_lim),
      .position(position), .motorless_test_en_q(motorless_test_en_q),
      .enc_res_q(enc_res_q), .enc_type_q(enc_type_q), .ot_warning_en_q(ot_warning_en_q),
      .maint_warning_en_q(maint_warning_en_q), .fwd_ot_q(fwd_ot_q), .rev_ot_q(rev_ot_q),
      .write_reject_q(write_reject_q));

   always #2.5 mclk = ~mclk;

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge mclk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata_q;
   endtask : rd

   // settings only reach the outputs through a restart
   task automatic restart;
      wr(`OFS_RESTART, 16'h0001);
      repeat (3) @(posedge mclk);
      #1;
   endtask : restart

   task automatic t_reset;
      logic [15:0] d;
      for (int a = 0; a < 8; a++) begin
         rd(a[3:0], d);
         check(d, 16'h0000);
      end
      check({15'h0, motorless_test_en_q}, 16'h0000);
   endtask : t_reset

   task automatic t_enc_res;
      logic [15:0] d;
      logic [15:0] v;
      for (int r = 0; r < 4; r++) begin
         v = 16'h0001 | 16'(r << 4) | 16'((r % 2) << 8);
         wr(`OFS_MOTORLESS_TEST, v);
         rd(`OFS_MOTORLESS_TEST, d);
         check(d, v);
         check({14'h0, enc_res_q}, 16'((r == 0) ? 0 : r - 1));
         restart;
         check({15'h0, motorless_test_en_q}, 16'h0001);
         check({14'h0, enc_res_q}, 16'(r));
         check({15'h0, enc_type_q}, 16'(r % 2));
      end
   endtask : t_enc_res

   task automatic t_warnings;
      logic [15:0] d;
      wr(`OFS_OT_WARNING, `MAX_OT_WARNING);
      wr(`OFS_MAINT_WARNING, `MAX_MAINT_WARNING);
      restart;
      check({15'h0, ot_warning_en_q}, 16'h0001);
      check({15'h0, maint_warning_en_q}, 16'h0001);
      rd(`OFS_ACTIVE_STATUS, d);
      check(d & 16'h007f, 16'h007e);
      wr(`OFS_OT_WARNING, 16'h0000);
      wr(`OFS_MAINT_WARNING, 16'h0010);
      wr(`OFS_MOTORLESS_TEST, 16'h0000);
      restart;
      check({15'h0, ot_warning_en_q}, 16'h0000);
      check({15'h0, maint_warning_en_q}, 16'h0000);
      check({15'h0, motorless_test_en_q}, 16'h0000);
   endtask : t_warnings

   task automatic t_reject;
      logic [15:0] d;
      wr(`OFS_MOTORLESS_TEST, 16'h0141);
      wr(`OFS_OT_RELEASE, 16'h0012);
      rd(`OFS_MOTORLESS_TEST, d);
      check(d, 16'h0000);
      rd(`OFS_OT_RELEASE, d);
      check(d, 16'h0000);
      rd(`OFS_OT_STATUS, d);
      check(d & 16'h0004, 16'h0004);
      wr(`OFS_RESERVED_WORD, 16'h0001);
      rd(`OFS_RESERVED_WORD, d);
      check(d, 16'h0000);
      wr(`OFS_RESERVED_WORD, 16'h0000);
      rd(`OFS_OT_STATUS, d);
      check(d & 16'h0004, 16'h0004);
      // unmapped place must neither store nor answer
      wr(4'h8, 16'h1234);
      rd(4'h8, d);
      check(d, 16'h0000);
      restart;
      check({15'h0, write_reject_q}, 16'h0000);
   endtask : t_reject

   task automatic t_ot_level;
      @(posedge mclk);
      fwd_lim <= 1'b1;
      @(posedge mclk);
      fwd_lim <= 1'b0;
      rev_lim <= 1'b1;
      #1 check({14'h0, fwd_ot_q, rev_ot_q}, 16'h0002);
      @(posedge mclk);
      rev_lim <= 1'b0;
      #1 check({14'h0, fwd_ot_q, rev_ot_q}, 16'h0001);
      @(posedge mclk);
      #1 check({14'h0, fwd_ot_q, rev_ot_q}, 16'h0000);
   endtask : t_ot_level

   task automatic t_ot_position;
      wr(`OFS_OT_RELEASE, 16'h0001);
      restart;
      @(posedge mclk);
      fwd_lim  <= 1'b1;
      position <= 32'd10;
      @(posedge mclk);
      position <= 32'd11;
      #1 check({15'h0, fwd_ot_q}, 16'h0000);
      @(posedge mclk);
      fwd_lim  <= 1'b0;
      rev_lim  <= 1'b1;
      position <= 32'd5;
      #1 check({15'h0, fwd_ot_q}, 16'h0001);
      @(posedge mclk);
      position <= 32'd4;
      #1 check({14'h0, fwd_ot_q, rev_ot_q}, 16'h0000);
      @(posedge mclk);
      rev_lim <= 1'b0;
      #1 check({15'h0, rev_ot_q}, 16'h0001);
   endtask : t_ot_position

   task automatic close_out;
      $display("errors %0d checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : close_out

   initial begin
      repeat (8) @(posedge mclk);
      sys_rst <= 1'b0;
      t_reset();
      t_enc_res();
      t_warnings();
      t_reject();
      t_ot_level();
      t_ot_position();
      close_out();
   end

   // whole run is well under a thousand cycles
   initial begin
      repeat (20000) @(posedge mclk);
      errors++;
      close_out();
   end
endmodule : drive_application_selection_params_tb_top
